// *** rtl/tlir_core_prio.sv ***
// Core event ranker: picks the highest priority pending event class.
`timescale 1ns/1ps
`include "tlir_defines.svh"
module tlir_core_prio (
    input  wire logic  mclk,    // System clock.
    input  wire logic  resetn,  // Asynchronous reset, active low.
    tlir_evt_if.prio   ev       // Pending events in, winner out.
);
    import tlir_pkg::*;

    // ======================================================================
    // Fixed priority, lowest index wins
    logic [`TLIR_NUM_EVT-1:0] pend_ok;
    tlir_evt_t                next_top;

    // The reserved slot can never win even if something drives it.
    assign pend_ok = ev.evt_pend & ~(`TLIR_NUM_EVT'(1) << `TLIR_EVT_RSVD_BIT); // see R3

    always_comb begin
        next_top = TLIR_EVT_EMULATION;
        for (int i = `TLIR_NUM_EVT - 1; i >= 0; i--) begin
            if (pend_ok[i]) begin
                next_top = tlir_evt_t'(i[3:0]); // see R3
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ev.evt_top   <= TLIR_EVT_EMULATION;
            ev.evt_valid <= 1'b0;
        end else begin
            ev.evt_top   <= next_top; // see R5
            ev.evt_valid <= |pend_ok;
        end
    end

    // ======================================================================
    // Checks
    a_evt_emu_first: assert property (@(posedge mclk) disable iff (!resetn) // see R3
        ev.evt_pend[0] |=> ev.evt_valid && ev.evt_top == TLIR_EVT_EMULATION)
        else $error("emulation event did not win");
    a_evt_gp_order: assert property (@(posedge mclk) disable iff (!resetn) // see R3
        (ev.evt_pend[8] && ev.evt_pend[15] && ev.evt_pend[7:0] == 8'h00)
        |=> ev.evt_top == TLIR_EVT_GP8)
        else $error("level 8 did not beat level 15");
    a_evt_idle: assert property (@(posedge mclk) disable iff (!resetn) // see R5
        (pend_ok == '0) |=> !ev.evt_valid)
        else $error("event reported with nothing pending");
endmodule

// *** rtl/tlir_defines.svh ***
// Constants of the two-level interrupt router: offsets, reset values and field layout.
`ifndef TLIR_DEFINES_SVH
`define TLIR_DEFINES_SVH

// ==========================================================================
// Sizes and field layout
`define TLIR_NUM_SRC        26
`define TLIR_NUM_EVT        16
`define TLIR_NUM_GP         9
`define TLIR_GP_BASE        7
`define TLIR_FLD_W          4
`define TLIR_FLD_PER_REG    8
`define TLIR_NUM_ASSIGN     4
`define TLIR_EVT_RSVD_BIT   4

// ==========================================================================
// Register offsets (byte addresses)
`define TLIR_OFS_ASSIGN0    8'h00
`define TLIR_OFS_ASSIGN1    8'h04
`define TLIR_OFS_ASSIGN2    8'h08
`define TLIR_OFS_ASSIGN3    8'h0C
`define TLIR_OFS_MASK       8'h10
`define TLIR_OFS_STATUS     8'h14
`define TLIR_OFS_WAKE_EN    8'h18
`define TLIR_OFS_IRQ_STAT   8'h1C
`define TLIR_OFS_IRQ_CLR    8'h20
`define TLIR_OFS_IRQ_EN     8'h24
`define TLIR_OFS_CORE_STAT  8'h28
`define TLIR_OFS_CTRL       8'h2C

// ==========================================================================
// Reset values and fixed bit positions
`define TLIR_RST_ASSIGN0    32'h0000_0000
`define TLIR_RST_ASSIGN1    32'h1100_0000
`define TLIR_RST_ASSIGN2    32'h3333_2222
`define TLIR_RST_ASSIGN3    32'h0000_0033
`define TLIR_RSVD_SRC       26'h000_0C00
`define TLIR_CTRL_SLEEP     0
`define TLIR_CTRL_BYPASS    1
`define TLIR_IRQ_WAKE       0
`define TLIR_IRQ_SRC        1
`define TLIR_IRQ_W          2

`endif

// *** rtl/tlir_evt_if.sv ***
// Interface between the router top, the core event ranker and the wakeup logic.
`timescale 1ns/1ps
`include "tlir_defines.svh"
interface tlir_evt_if;
    import tlir_pkg::*;
    logic [`TLIR_NUM_EVT-1:0] evt_pend;
    tlir_evt_t                evt_top;
    logic                     evt_valid;
    logic [`TLIR_NUM_SRC-1:0] wake_src;
    logic                     sleep_req;
    logic                     bypass;
    logic                     sleeping;
    logic                     wake;
    logic                     resume_full;

    modport top  (output evt_pend, wake_src, sleep_req, bypass,
                  input  evt_top, evt_valid, sleeping, wake, resume_full);
    modport prio (input  evt_pend, output evt_top, evt_valid);
    modport pwr  (input  wake_src, sleep_req, bypass,
                  output sleeping, wake, resume_full);
endinterface

// *** rtl/tlir_pkg.sv ***
// Types shared by the two-level interrupt router modules.
package tlir_pkg;

    // ======================================================================
    // Event vector table entries in priority order, highest first.
    typedef enum logic [3:0] {
        TLIR_EVT_EMULATION, TLIR_EVT_RESET, TLIR_EVT_NMI, TLIR_EVT_EXCEPTION,
        TLIR_EVT_RSVD, TLIR_EVT_HW_ERROR, TLIR_EVT_CORE_TIMER,
        TLIR_EVT_GP7, TLIR_EVT_GP8, TLIR_EVT_GP9, TLIR_EVT_GP10, TLIR_EVT_GP11,
        TLIR_EVT_GP12, TLIR_EVT_GP13, TLIR_EVT_GP14, TLIR_EVT_GP15
    } tlir_evt_t;

    typedef enum logic {
        TLIR_ST_RUN,
        TLIR_ST_SLEEP
    } tlir_pwr_t;

endpackage

// *** rtl/tlir_top.sv ***
// Two-level interrupt router top: system router, registers, core ranker and wakeup.
//
// Summary of operation
// R1: Peripheral requests pass the system router before reaching core general-purpose inputs.
// R2: The core controller has nine general-purpose levels, 7 to 15.
// R3: Fixed priority, 0 highest: dedicated events 0-6, then levels 7-15 ascending.
// R4: Levels 7 to 13 serve peripherals; 14 and 15 suggested for software.
// R5: Each event class, each level included, has its own vector table entry.
// R6: Reset loads a default mapping; assignment writes change each source's level.
// R7: Assignment value n selects core level 7 plus n.
// R8: After reset sources 0 to 13 go to level 7.
// R9: After reset 14-15 to level 8, 16-19 level 9, 20-25 level 10.
// R10: Four assignment registers of eight fields cover sources 0-7, 8-15, 16-23, 24-25.
// R11: Sources 0-25, 10 and 11 reserved; one mask, status, wake register.
// R12: Source numbers are fixed by the peripheral wired to each input.
// R13: A pending wake-enabled source ends sleep; bypass picks the resume mode.
// R14: A masked source drives no level but its status still shows the request.
// R15: A level is asserted while any unmasked source mapped to it is pending.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "tlir_defines.svh"
module tlir_top (
    input  wire logic                     mclk,            // System clock, 100 MHz.
    input  wire logic                     resetn,          // Asynchronous reset, active low.
    input  wire logic [7:0]               addr,            // Register byte address.
    input  wire logic [31:0]              wdata,           // Write data.
    input  wire logic                     wr,              // Write strobe.
    input  wire logic                     rd,              // Read strobe.
    output logic [31:0]                   rdata,           // Read data, cycle after rd.
    input  wire logic [`TLIR_NUM_SRC-1:0] src_irq,         // Peripheral requests.
    input  wire logic                     emu_evt,         // Emulation event.
    input  wire logic                     core_reset_evt,  // Core reset event.
    input  wire logic                     nmi_evt,         // Nonmaskable event.
    input  wire logic                     exc_evt,         // Exception event.
    input  wire logic                     hw_err_evt,      // Hardware error event.
    input  wire logic                     core_timer_evt,  // Core timer event.
    output logic [`TLIR_NUM_GP-1:0]       gp_level,        // Levels 7..15, bit 0 is 7.
    output logic                          core_evt_valid,  // An event class is pending.
    output tlir_pkg::tlir_evt_t           core_evt_entry,  // Winning vector entry.
    output logic                          core_sleep,      // Core clock stopped.
    output logic                          resume_full,     // Resumed in full-on mode.
    output logic                          irq              // Router interrupt.
);
    import tlir_pkg::*;

    localparam int NS = `TLIR_NUM_SRC;
    localparam int NG = `TLIR_NUM_GP;
    localparam int FW = `TLIR_FLD_W;

    tlir_evt_if ev ();

    // ======================================================================
    // Registers
    logic [31:0]           assign_reg [`TLIR_NUM_ASSIGN];
    logic [NS-1:0]         mask;
    logic [NS-1:0]         status;
    logic [NS-1:0]         wake_en;
    logic [`TLIR_IRQ_W-1:0] irq_stat;
    logic [`TLIR_IRQ_W-1:0] irq_en;
    logic                  bypass;
    logic                  sleep_req;
    logic                  any_src_q;
    logic                  wake_q;

    // Field of source s as a core interrupt identifier.
    function automatic logic [FW-1:0] src_field(input int s);
        src_field = assign_reg[s / `TLIR_FLD_PER_REG][(s % `TLIR_FLD_PER_REG) * FW +: FW];
    endfunction

    // Identifier to one-hot level; values past level 15 route nowhere.
    function automatic logic [NG-1:0] id_to_level(input logic [FW-1:0] id);
        id_to_level = '0;
        if (id < FW'(NG)) begin
            id_to_level[id] = 1'b1; // see R7
        end
    endfunction

    function automatic logic [31:0] reset_assign(input int r);
        case (r)
            0:       reset_assign = `TLIR_RST_ASSIGN0; // see R8
            1:       reset_assign = `TLIR_RST_ASSIGN1; // see R9
            2:       reset_assign = `TLIR_RST_ASSIGN2; // see R9
            default: reset_assign = `TLIR_RST_ASSIGN3; // see R9
        endcase
    endfunction

    // Only the fields that exist in register 3 are writable.
    localparam logic [31:0] A3_KEEP = 32'h0000_00FF;

    generate
        for (genvar r = 0; r < `TLIR_NUM_ASSIGN; r++) begin : g_assign
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    assign_reg[r] <= reset_assign(r); // see R6
                end else if (wr && addr == (`TLIR_OFS_ASSIGN0 + 8'(4 * r))) begin
                    assign_reg[r] <= (r == `TLIR_NUM_ASSIGN - 1) ? (wdata & A3_KEEP)
                                                                 : wdata; // see R10
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mask    <= '0;
            wake_en <= '0;
        end else if (wr) begin
            if (addr == `TLIR_OFS_MASK) begin
                mask <= wdata[NS-1:0] & ~`TLIR_RSVD_SRC; // see R11
            end
            if (addr == `TLIR_OFS_WAKE_EN) begin
                wake_en <= wdata[NS-1:0] & ~`TLIR_RSVD_SRC; // see R11
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bypass    <= 1'b0;
            sleep_req <= 1'b0;
        end else begin
            sleep_req <= wr && addr == `TLIR_OFS_CTRL && wdata[`TLIR_CTRL_SLEEP];
            if (wr && addr == `TLIR_OFS_CTRL) begin
                bypass <= wdata[`TLIR_CTRL_BYPASS];
            end
        end
    end

    // ======================================================================
    // System router
    // Status is the raw request whatever the mask says, so software can poll.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            status <= '0;
        end else begin
            status <= src_irq & ~`TLIR_RSVD_SRC; // see R14
        end
    end

    logic [NG-1:0] src_hit [NS];
    logic [NG-1:0] next_gp_level;

    generate
        for (genvar s = 0; s < NS; s++) begin : g_src
            // Each input index is a fixed peripheral; the router never renumbers.
            assign src_hit[s] = (status[s] && mask[s]) ? id_to_level(src_field(s))
                                                        : '0; // see R12
        end
    endgenerate

    always_comb begin
        next_gp_level = '0;
        for (int s = 0; s < NS; s++) begin
            next_gp_level = next_gp_level | src_hit[s]; // see R15
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            gp_level <= '0;
        end else begin
            gp_level <= next_gp_level; // see R1
        end
    end

    // ======================================================================
    // Core controller and wakeup
    // Levels 14 and 15 are routable too; keeping them for software is up to the user.
    assign ev.evt_pend = {gp_level, core_timer_evt, hw_err_evt, 1'b0, // see R4
                          exc_evt, nmi_evt, core_reset_evt, emu_evt}; // see R2
    assign ev.wake_src  = status & wake_en; // see R13
    assign ev.sleep_req = sleep_req;
    assign ev.bypass    = bypass;

    tlir_core_prio u_prio (
        .mclk   (mclk),
        .resetn (resetn),
        .ev     (ev.prio)
    );

    tlir_wake u_wake (
        .mclk   (mclk),
        .resetn (resetn),
        .pw     (ev.pwr)
    );

    assign core_evt_valid = ev.evt_valid;
    assign core_evt_entry = ev.evt_top;
    assign core_sleep     = ev.sleeping;
    assign resume_full    = ev.resume_full;

    // ======================================================================
    // Router interrupt
    logic any_src;
    logic [`TLIR_IRQ_W-1:0] irq_set;

    assign any_src = |(status & mask);
    assign irq_set = {any_src && !any_src_q, ev.wake};

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            any_src_q <= 1'b0;
            wake_q    <= 1'b0;
            irq_stat  <= '0;
            irq_en    <= '0;
        end else begin
            any_src_q <= any_src;
            wake_q    <= ev.wake;
            // A set in the same cycle as a clear keeps the bit.
            if (wr && addr == `TLIR_OFS_IRQ_CLR) begin
                irq_stat <= (irq_stat & ~wdata[`TLIR_IRQ_W-1:0]) | irq_set;
            end else begin
                irq_stat <= irq_stat | irq_set;
            end
            if (wr && addr == `TLIR_OFS_IRQ_EN) begin
                irq_en <= wdata[`TLIR_IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irq_stat & irq_en);

    // ======================================================================
    // Read port
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = '0;
        case (addr)
            `TLIR_OFS_ASSIGN0:   next_rdata = assign_reg[0];
            `TLIR_OFS_ASSIGN1:   next_rdata = assign_reg[1];
            `TLIR_OFS_ASSIGN2:   next_rdata = assign_reg[2];
            `TLIR_OFS_ASSIGN3:   next_rdata = assign_reg[3];
            `TLIR_OFS_MASK:      next_rdata = 32'(mask);
            `TLIR_OFS_STATUS:    next_rdata = 32'(status);
            `TLIR_OFS_WAKE_EN:   next_rdata = 32'(wake_en);
            `TLIR_OFS_IRQ_STAT:  next_rdata = 32'(irq_stat);
            `TLIR_OFS_IRQ_EN:    next_rdata = 32'(irq_en);
            `TLIR_OFS_CORE_STAT: next_rdata = {ev.resume_full, ev.sleeping, 13'h0000,
                                               ev.evt_valid, 4'(ev.evt_top),
                                               3'h0, gp_level};
            `TLIR_OFS_CTRL:      next_rdata = 32'(bypass) << `TLIR_CTRL_BYPASS;
            default:             next_rdata = '0;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata <= '0;
        end else begin
            rdata <= rd ? next_rdata : '0;
        end
    end

    // ======================================================================
    // Checks
    a_mask_gate: assert property (@(posedge mclk) disable iff (!resetn) // see R14
        (status[0] && !mask[0] && status[NS-1:1] == '0) |=> gp_level == '0)
        else $error("masked source drove a level");
    a_status_raw: assert property (@(posedge mclk) disable iff (!resetn) // see R14
        ##1 status == ($past(src_irq) & ~`TLIR_RSVD_SRC))
        else $error("status does not follow raw request");
    a_reserved_zero: assert property (@(posedge mclk) disable iff (!resetn) // see R11
        (status[11:10] == 2'b00) && (mask[11:10] == 2'b00))
        else $error("reserved source bit set");
    a_route_level: assert property (@(posedge mclk) disable iff (!resetn) // see R15
        (status[20] && mask[20] && src_field(20) == 4'h3) |=> gp_level[3])
        else $error("unmasked source did not reach its level");
    a_level_cause: assert property (@(posedge mclk) disable iff (!resetn) // see R1
        gp_level != '0 |-> $past(status & mask) != '0)
        else $error("level raised without an unmasked source");
    a_read_latency: assert property (@(posedge mclk) disable iff (!resetn)
        (rd && addr == `TLIR_OFS_MASK) |=> rdata == 32'($past(mask)))
        else $error("mask read wrong or late");
    a_irq_sticky: assert property (@(posedge mclk) disable iff (!resetn)
        ev.wake |=> irq_stat[`TLIR_IRQ_WAKE])
        else $error("wake event lost");
    a_default_map: assert property (@(posedge mclk) // see R8
        $rose(resetn) |-> assign_reg[0] == `TLIR_RST_ASSIGN0 &&
                          assign_reg[2] == `TLIR_RST_ASSIGN2)
        else $error("default mapping not loaded");
    a_remap_write: assert property (@(posedge mclk) disable iff (!resetn) // see R6
        (wr && addr == `TLIR_OFS_ASSIGN1) |=> assign_reg[1] == $past(wdata))
        else $error("assignment write not taken");

    c_level7: cover property (@(posedge mclk) disable iff (!resetn) gp_level[0]);
    c_shared: cover property (@(posedge mclk) disable iff (!resetn)
        $countones(status & mask) > 1 && $onehot(gp_level));
    c_irq: cover property (@(posedge mclk) disable iff (!resetn) $rose(irq));
    c_wake_q: cover property (@(posedge mclk) disable iff (!resetn) wake_q);
endmodule

// *** rtl/tlir_wake.sv ***
// Sleep and wakeup control: leaves sleep on an enabled pending source.
`timescale 1ns/1ps
`include "tlir_defines.svh"
module tlir_wake (
    input  wire logic  mclk,    // System clock.
    input  wire logic  resetn,  // Asynchronous reset, active low.
    tlir_evt_if.pwr    pw       // Wake sources, sleep request, state out.
);
    import tlir_pkg::*;

    tlir_pwr_t state;
    logic      hit;

    assign hit = |pw.wake_src;

    // ======================================================================
    // Power state
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state          <= TLIR_ST_RUN;
            pw.wake        <= 1'b0;
            pw.resume_full <= 1'b1;
        end else begin
            pw.wake <= 1'b0;
            case (state)
                TLIR_ST_RUN: begin
                    // A request made while a wake source is already up is dropped.
                    if (pw.sleep_req && !hit) begin
                        state <= TLIR_ST_SLEEP;
                    end
                end
                TLIR_ST_SLEEP: begin
                    if (hit) begin
                        state          <= TLIR_ST_RUN; // see R13
                        pw.wake        <= 1'b1;
                        pw.resume_full <= !pw.bypass; // see R13
                    end
                end
                default: state <= TLIR_ST_RUN;
            endcase
        end
    end

    assign pw.sleeping = (state == TLIR_ST_SLEEP);

    a_wake_exit: assert property (@(posedge mclk) disable iff (!resetn) // see R13
        (pw.sleeping && hit) |=> (!pw.sleeping && pw.wake))
        else $error("enabled source did not wake the core");
    a_wake_mode: assert property (@(posedge mclk) disable iff (!resetn) // see R13
        (pw.sleeping && hit && pw.bypass) |=> !pw.resume_full)
        else $error("bypass set but full-on mode chosen");
    c_wake_seen: cover property (@(posedge mclk) disable iff (!resetn)
        pw.sleeping ##1 pw.wake);
endmodule

// *** tb/tlir_periph_model.sv ***
// Partner model: peripheral sources and dedicated core events as held levels.
`timescale 1ns/1ps
module tlir_periph_model (
    input  wire logic        mclk,      // System clock.
    input  wire logic        resetn,    // Asynchronous reset, active low.
    input  wire logic [25:0] req,       // Source requests wanted by the bench.
    input  wire logic [5:0]  evt_req,   // Dedicated events wanted by the bench.
    output logic      [25:0] src_irq,   // Level requests into the router.
    output logic      [5:0]  core_evt   // Dedicated events, priority 0 first, slot 4 skipped.
);
    // ====================================================================
    // Request drivers
    // A peripheral keeps its request up until its handler withdraws it, so levels are held.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            src_irq  <= 26'h0;
            core_evt <= 6'h0;
        end else begin
            src_irq  <= req;
            core_evt <= evt_req;
        end
    end
endmodule

// *** tb/two_level_interrupt_router_bench.sv ***
// Self-checking bench for the two-level interrupt router.
`timescale 1ns/1ps
`include "tlir_defines.svh"
module two_level_interrupt_router_bench;
    import tlir_pkg::*;
    logic        mclk, resetn, wr, rd, rd_seen;
    logic        core_evt_valid, core_sleep, resume_full, irq;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    logic [31:0] asg [4];
    logic [31:0] exp_q [$];
    logic [25:0] req, src_irq;
    logic [5:0]  evt_req, cev;
    logic [8:0]  gp_level;
    tlir_evt_t   core_evt_entry;
    int          num_errors = 0;
    int          checked = 0;
    int          s, k, lv;

    tlir_periph_model pm (.mclk(mclk), .resetn(resetn), .req(req), .evt_req(evt_req),
        .src_irq(src_irq), .core_evt(cev));
    tlir_top dut (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .src_irq(src_irq), .emu_evt(cev[0]),
        .core_reset_evt(cev[1]), .nmi_evt(cev[2]), .exc_evt(cev[3]), .hw_err_evt(cev[4]),
        .core_timer_evt(cev[5]), .gp_level(gp_level), .core_evt_valid(core_evt_valid),
        .core_evt_entry(core_evt_entry), .core_sleep(core_sleep),
        .resume_full(resume_full), .irq(irq));

    // ====================================================================
    // Compare, bus and routing tasks
    task automatic tally_and_finish();
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Each access leaves one idle cycle so a strobe is never lowered and raised at one edge.
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
    endtask
    function automatic logic [3:0] dflt(input int n);
        return (n < 14) ? 4'h0 : (n < 16) ? 4'h1 : (n < 20) ? 4'h2 : 4'h3;
    endfunction
    task automatic route(input int n);
        logic [3:0] f;
        f = asg[n/8][4*(n%8)+:4];
        req <= 26'h1 << n;
        step(3);
        check(32'(gp_level), (n == 10 || n == 11 || f > 8) ? 32'h0 : 32'h1 << f);
        step(1);
        check(32'(core_evt_valid), (n == 10 || n == 11 || f > 8) ? 32'h0 : 32'h1);
        if (n != 10 && n != 11 && f < 9) check(32'(core_evt_entry), 32'h7 + f);
        req <= 26'h0;
        step(3);
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken there.
    always @(posedge mclk) begin
        rd_seen <= rd;
        if (rd_seen === 1'b1) check(rdata, exp_q.pop_front());
    end

    // ====================================================================
    // Clock, watchdog and main sequence
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        resetn  = 1'b0;
        wr      = 1'b0;
        rd      = 1'b0;
        rd_seen = 1'b0;
        addr    = 8'h00;
        wdata   = 32'h0;
        req     = 26'h0;
        evt_req = 6'h0;
        void'($urandom(74447));
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        step(1);
        for (k = 0; k < 4; k++) begin
            asg[k] = 32'h0;
            for (s = 8 * k; s < 8 * k + 8 && s < 26; s++) asg[k][4*(s%8)+:4] = dflt(s);
            rd_reg(8'(4 * k), asg[k]);
        end
        $display("done: default assignment");
        lv = $urandom;
        wr_reg(`TLIR_OFS_MASK, lv);
        rd_reg(`TLIR_OFS_MASK, lv & 32'h03FF_F3FF);
        wr_reg(`TLIR_OFS_MASK, 32'h03FF_FFFF);
        rd_reg(8'h30, 32'h0);
        rd_reg(`TLIR_OFS_IRQ_CLR, 32'h0);
        for (s = 0; s < 26; s++) route(s);
        $display("done: mask and default routing");
        asg[1] = $urandom & 32'h7777_7777;
        asg[2] = $urandom & 32'h7777_7777;
        asg[3] = 32'h0000_00A8;
        wr_reg(`TLIR_OFS_ASSIGN1, asg[1]);
        wr_reg(`TLIR_OFS_ASSIGN2, asg[2]);
        wr_reg(`TLIR_OFS_ASSIGN3, 32'hABCD_EFA8);
        rd_reg(`TLIR_OFS_ASSIGN1, asg[1]);
        rd_reg(`TLIR_OFS_ASSIGN2, asg[2]);
        rd_reg(`TLIR_OFS_ASSIGN3, asg[3]);
        for (s = 8; s < 26; s++) route(s);
        $display("done: remapping");
        req <= 26'h3;
        step(3);
        check(32'(gp_level), 32'h1);
        req <= 26'h2;
        step(3);
        check(32'(gp_level), 32'h1);
        wr_reg(`TLIR_OFS_MASK, 32'h03FF_FFFD);
        step(3);
        check(32'(gp_level), 32'h0);
        rd_reg(`TLIR_OFS_STATUS, 32'h2);
        $display("done: shared level and masking");
        wr_reg(`TLIR_OFS_MASK, 32'h03FF_FFFF);
        for (k = 0; k < 6; k++) begin
            evt_req <= 6'h1 << k;
            step(4);
            check(32'(core_evt_entry), (k < 4) ? k : k + 1);
        end
        evt_req <= 6'h0;
        $display("done: event priority");
        wr_reg(`TLIR_OFS_WAKE_EN, 32'h0000_4000);
        for (lv = 0; lv < 2; lv++) begin
            req <= 26'h0;
            step(3);
            wr_reg(`TLIR_OFS_IRQ_CLR, 32'h3);
            wr_reg(`TLIR_OFS_IRQ_EN, 32'h3);
            wr_reg(`TLIR_OFS_CTRL, {30'h0, lv[0], 1'b1});
            step(2);
            check(32'(core_sleep), 32'h1);
            req <= 26'h4000;
            for (k = 0; k < 20 && core_sleep !== 1'b0; k++) step(1);
            if (k == 20) begin
                num_errors++;
                tally_and_finish();
            end
            check(32'(resume_full), {31'h0, !lv[0]});
            step(2);
            check(32'(irq), 32'h1);
            rd_reg(`TLIR_OFS_IRQ_STAT, 32'h3);
            wr_reg(`TLIR_OFS_IRQ_EN, 32'h0);
            step(1);
            check(32'(irq), 32'h0);
        end
        wr_reg(`TLIR_OFS_IRQ_EN, 32'h3);
        wr_reg(`TLIR_OFS_IRQ_CLR, 32'h3);
        step(1);
        check(32'(irq), 32'h0);
        rd_reg(`TLIR_OFS_CTRL, 32'h2);
        lv = {16'h1, 4'h7 + asg[1][27:24], 3'h0, 9'h1 << asg[1][27:24]};
        rd_reg(`TLIR_OFS_CORE_STAT, lv);
        $display("done: sleep, wakeup and interrupt");
        tally_and_finish();
    end
endmodule
